// [tds_extrinsic_conditioner.sv]
// Purpose: scales and limits extrinsic information and reports its raw magnitude
// Assumes: two's complement extrinsic input from the map core
// Notes: extr_out is registered, one cycle after the input; extr_mag is combinational
`include "tds_params.svh"

module tds_extrinsic_conditioner import tds_pkg::*; #(
    parameter int EXTR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sync_reset,
    input wire logic [EXTR_W-1:0] extr_in,
    input wire logic extr_in_valid,
    input wire logic [6:0] limit,
    input wire logic [5:0] scale,
    output logic [EXTR_W-1:0] extr_out,
    output logic extr_out_valid,
    output logic [6:0] extr_mag
);

    logic neg;
    logic [EXTR_W-1:0] mag_raw;
    logic [EXTR_W+5:0] product;
    logic [EXTR_W-1:0] scaled;
    logic [EXTR_W-1:0] limited;

    assign neg = extr_in[EXTR_W-1];
    assign mag_raw = neg ? EXTR_W'(~extr_in + 1'b1) : extr_in;
    assign extr_mag = (mag_raw > EXTR_W'(`TDS_MAG_MAX)) ? `TDS_MAG_MAX : mag_raw[6:0];
    // multiply by scale / 32
    assign product = mag_raw * scale;
    assign scaled = product[EXTR_W+4:`TDS_SCALE_SHIFT];
    // clamp magnitude to the limit
    assign limited = (scaled > EXTR_W'(limit)) ? EXTR_W'(limit) : scaled;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extr_out <= '0;
            extr_out_valid <= 1'b0;
        end else if (sync_reset) begin
            extr_out <= '0;
            extr_out_valid <= 1'b0;
        end else begin
            extr_out <= neg ? EXTR_W'(~limited + 1'b1) : limited;
            extr_out_valid <= extr_in_valid;
        end
    end

endmodule

// [tds_params.svh]
// Purpose: offsets, field positions, reset values and counts of the turbo decode sequencer
// Assumes: included by bare name from the design modules
// Notes: definitions only
`ifndef TDS_PARAMS_SVH
`define TDS_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define TDS_ADDR_CTRL 12'h000
`define TDS_ADDR_CONFIG 12'h004
`define TDS_ADDR_EXTR 12'h008
`define TDS_ADDR_STATUS 12'h00c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TDS_CTRL_START 0
`define TDS_CTRL_MAXLOG 1
`define TDS_CFG_KS_LSB 0
`define TDS_CFG_RATE_LSB 4
`define TDS_CFG_NI_LSB 8
`define TDS_CFG_MODE_LSB 16
`define TDS_CFG_SLD_LSB 18
`define TDS_EXT_LIM_LSB 0
`define TDS_EXT_SCL_LSB 8
`define TDS_EXT_THR_LSB 16
`define TDS_ST_DONE 0
`define TDS_ST_DBUSY 1
`define TDS_ST_IBUSY 2
`define TDS_ST_STOPPED 3
`define TDS_ST_IDX_LSB 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TDS_KS_RST 4'h0
`define TDS_RATE_RST 3'h3
`define TDS_NI_RST 8'h00
`define TDS_MODE_RST 2'h0
`define TDS_SLD_RST 2'h0
`define TDS_LIMIT_RST 7'h60
`define TDS_SCALE_RST 6'h20
`define TDS_THR_RST 7'h17

// ----------------------------------------------------------------
// block and pipeline counts
// ----------------------------------------------------------------
`define TDS_K_UNIT 14'h06f8
`define TDS_KS_MAX 4'h8
`define TDS_TAIL_LEN 15'h0004
`define TDS_DELAY_SHORT 15'h008a
`define TDS_DELAY_MID 15'h010a
`define TDS_DELAY_LONG 15'h020a
`define TDS_SCALE_SHIFT 5
`define TDS_MAG_MAX 7'h7f

`endif

// [tds_pkg.sv]
// Purpose: shared types of the turbo decode sequencer
// Assumes: nothing beyond the parameter header
// Notes: numeric constants live in tds_params.svh
package tds_pkg;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TDS_IDLE = 2'b01,
        TDS_RUN = 2'b10
    } tds_state_t;

    typedef enum logic [1:0] {
        TDS_STOP_FIXED = 2'h0,
        TDS_STOP_ODD = 2'h1,
        TDS_STOP_EVEN = 2'h2,
        TDS_STOP_ANY = 2'h3
    } tds_stop_mode_t;

endpackage

// [tds_rx_ram.sv]
// Purpose: received-symbol ram seen from the sequencer's read port
// Assumes: rate 1/3 block, lanes 3 to 6 unused and presented as punctured
// Notes: data follows the address by one clock; between reads the lanes toggle
module tds_rx_ram (
    input wire logic pclk,
    input wire logic rx_read_strobe,
    input wire logic [13:0] rx_read_addr,
    output logic [5:0] soft_lane0 = 6'h2a,
    output logic [5:0] soft_lane1 = 6'h15,
    output logic [5:0] soft_lane2 = 6'h2a,
    output logic [5:0] soft_lane3 = 6'h15,
    output logic [5:0] soft_lane4 = 6'h2a,
    output logic [5:0] soft_lane5 = 6'h15,
    output logic [5:0] soft_lane6 = 6'h2a
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge pclk) begin
        if (rx_read_strobe) begin
            soft_lane0 <= rx_read_addr[5:0];
            soft_lane1 <= {rx_read_addr[1], 5'h11};
            soft_lane2 <= {rx_read_addr[2:0], 3'h4};
            {soft_lane3, soft_lane4, soft_lane5, soft_lane6} <= 24'h0;
        end else begin
            {soft_lane0, soft_lane1, soft_lane2, soft_lane3, soft_lane4, soft_lane5, soft_lane6} <=
                ~{soft_lane0, soft_lane1, soft_lane2, soft_lane3, soft_lane4, soft_lane5, soft_lane6};
        end
    end
endmodule

// [tds_seq_properties.sv]
// Purpose: timing relations of the sequencer's read, output and status ports
// Assumes: one clock domain
// Notes: bound to every sequencer instance
module tds_seq_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic rx_read_strobe,
    input wire logic [13:0] rx_read_addr,
    input wire logic [7:0] half_iter_index,
    input wire logic decoded_ready,
    input wire logic decode_done,
    input wire logic decoder_busy,
    input wire logic output_terminal_count,
    input wire logic input_ram_busy,
    input wire logic input_terminal_count
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    itc_on_read_a: assert property (input_terminal_count |-> rx_read_strobe)
        else $error("input terminal count outside a read");
    itc_pulse_a: assert property (input_terminal_count |=> !input_terminal_count && !input_ram_busy)
        else $error("input terminal count not a single pulse ending ram use");
    // busy drops on the same edge that raises the terminal count
    ram_busy_fall_a: assert property ($fell(input_ram_busy) |-> input_terminal_count)
        else $error("input ram busy fell without terminal count");
    addr_first_a: assert property ($rose(rx_read_strobe) |-> rx_read_addr == 14'h0)
        else $error("read pass does not start at address zero");
    addr_step_a: assert property (rx_read_strobe && $past(rx_read_strobe) |->
        rx_read_addr == $past(rx_read_addr) + 14'h1) else $error("read address skipped");
    idx_step_a: assert property ($changed(half_iter_index) |->
        half_iter_index == $past(half_iter_index) + 8'h1 || half_iter_index == 8'h0)
        else $error("half iteration index jumped");
    busy_not_done_a: assert property (decoder_busy |-> !decode_done)
        else $error("done while busy");
    otc_end_a: assert property (output_terminal_count && !start |=> decode_done && !decoder_busy)
        else $error("decode did not end after last bit");
    otc_ready_a: assert property (output_terminal_count |-> decoded_ready)
        else $error("output terminal count without decoded bit");
endmodule

bind tds_sequencer tds_seq_checker i_chk (.pclk, .presetn, .start, .rx_read_strobe, .rx_read_addr,
    .half_iter_index, .decoded_ready, .decode_done, .decoder_busy, .output_terminal_count,
    .input_ram_busy, .input_terminal_count);

// [tds_sequencer.sv]
// Purpose: sequences an iterative 16-state turbo decode around an external map core
// Assumes: synchronous-read received-symbol ram, map core fed from map_lanes and extr_apriori
// Notes: apb slave with zero wait states; config captured at start
//
// The APB slave port and the address map were chosen for this implementation.

`include "tds_params.svh"

// Operation
// - soft lanes are 6-bit signed magnitude
// - half-iteration index counts up to setting
// - delay select picks 138, 266 or 522
// - extrinsic magnitude clamped to limit
// - extrinsic scaled by scale over 32
// - stop mode: fixed, odd, even or any
// - read strobe with 14-bit read address
// - each half iteration rereads K+4 symbols
// - input ram busy and terminal count
// - start ignored while running except final cycle
// - synchronous active-high reset clears everything
// - decoded bits in final half iteration
// - even index error bits, first encoder
// - odd index error bits, second encoder
// - done low while decoding, high after
// - decoder busy and output terminal count
// - decode time bounded by half-iteration lengths
// - status outputs come straight from flip-flops
// - block length is 1784 times select+1, select capped at 8
// - stop when minimum magnitude exceeds threshold
// - one more half iteration after stopping
module tds_sequencer import tds_pkg::*; #(
    parameter int ADDR_W = 14,
    parameter int LANE_W = 6,
    parameter int EXTR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sync_reset,
    input wire logic start,
    output logic rx_read_strobe,
    output logic [ADDR_W-1:0] rx_read_addr,
    input wire logic [LANE_W-1:0] soft_lane0,
    input wire logic [LANE_W-1:0] soft_lane1,
    input wire logic [LANE_W-1:0] soft_lane2,
    input wire logic [LANE_W-1:0] soft_lane3,
    input wire logic [LANE_W-1:0] soft_lane4,
    input wire logic [LANE_W-1:0] soft_lane5,
    input wire logic [LANE_W-1:0] soft_lane6,
    output logic [7*LANE_W-1:0] map_lanes,
    output logic [1:0] map_delay_select,
    output logic map_max_log,
    input wire logic [EXTR_W-1:0] map_extr,
    input wire logic map_extr_valid,
    output logic [EXTR_W-1:0] extr_apriori,
    output logic extr_apriori_valid,
    input wire logic map_decision,
    input wire logic [ADDR_W-1:0] perm_addr,
    output logic [ADDR_W-1:0] check_addr,
    input wire logic [6:0] check_sign,
    output logic decoded_ready,
    output logic [ADDR_W-1:0] decoded_addr,
    output logic decoded_bit,
    output logic [3:0] err_estimate,
    output logic [7:0] half_iter_index,
    output logic decode_done,
    output logic decoder_busy,
    output logic output_terminal_count,
    output logic input_ram_busy,
    output logic input_terminal_count
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W < 14) begin : g_bad_addr
        $error("address width below 14 cannot hold the largest block");
    end
    if (LANE_W != 6) begin : g_bad_lane
        $error("soft lanes must be 6 bits wide");
    end
    if (EXTR_W < 8) begin : g_bad_extr
        $error("extrinsic width below 8 cannot hold the limit");
    end

    // ----------------------------------------------------------------
    // apb register file
    // ----------------------------------------------------------------
    logic [3:0] reg_ks;
    logic [2:0] reg_rate;
    logic [7:0] reg_ni;
    logic [1:0] reg_mode;
    logic [1:0] reg_sld;
    logic reg_maxlog;
    logic [6:0] reg_limit;
    logic [5:0] reg_scale;
    logic [6:0] reg_thr;
    logic stopped_early;

    wire sel_ctrl = paddr == `TDS_ADDR_CTRL;
    wire sel_cfg = paddr == `TDS_ADDR_CONFIG;
    wire sel_ext = paddr == `TDS_ADDR_EXTR;
    wire sel_st = paddr == `TDS_ADDR_STATUS;
    wire addr_hit = sel_ctrl | sel_cfg | sel_ext | sel_st;
    wire apb_acc = psel & penable;
    wire apb_wr = apb_acc & pwrite;
    wire sw_start = apb_wr & sel_ctrl & pwdata[`TDS_CTRL_START];
    wire start_req = start | sw_start;

    assign pready = 1'b1;
    assign pslverr = apb_acc & ~addr_hit;
    assign prdata = !apb_acc ? 32'h0 :
        sel_ctrl ? {30'h0, reg_maxlog, 1'b0} :
        sel_cfg ? {12'h0, reg_sld, reg_mode, reg_ni, 1'b0, reg_rate, reg_ks} :
        sel_ext ? {9'h0, reg_thr, 2'h0, reg_scale, 1'b0, reg_limit} :
        sel_st ? {16'h0, half_iter_index, 4'h0, stopped_early, input_ram_busy, decoder_busy, decode_done} :
        32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_maxlog <= 1'b0;
            {reg_sld, reg_mode, reg_ni, reg_rate, reg_ks} <=
                {`TDS_SLD_RST, `TDS_MODE_RST, `TDS_NI_RST, `TDS_RATE_RST, `TDS_KS_RST};
            {reg_thr, reg_scale, reg_limit} <= {`TDS_THR_RST, `TDS_SCALE_RST, `TDS_LIMIT_RST};
        end else if (sync_reset) begin
            reg_maxlog <= 1'b0;
            {reg_sld, reg_mode, reg_ni, reg_rate, reg_ks} <=
                {`TDS_SLD_RST, `TDS_MODE_RST, `TDS_NI_RST, `TDS_RATE_RST, `TDS_KS_RST};
            {reg_thr, reg_scale, reg_limit} <= {`TDS_THR_RST, `TDS_SCALE_RST, `TDS_LIMIT_RST};
        end else if (apb_wr) begin
            if (sel_ctrl) begin
                reg_maxlog <= pwdata[`TDS_CTRL_MAXLOG];
            end
            if (sel_cfg) begin
                reg_ks <= pwdata[`TDS_CFG_KS_LSB +: 4];
                reg_rate <= pwdata[`TDS_CFG_RATE_LSB +: 3];
                reg_ni <= pwdata[`TDS_CFG_NI_LSB +: 8];
                reg_mode <= pwdata[`TDS_CFG_MODE_LSB +: 2];
                reg_sld <= pwdata[`TDS_CFG_SLD_LSB +: 2];
            end
            if (sel_ext) begin
                reg_limit <= pwdata[`TDS_EXT_LIM_LSB +: 7];
                reg_scale <= pwdata[`TDS_EXT_SCL_LSB +: 6];
                reg_thr <= pwdata[`TDS_EXT_THR_LSB +: 7];
            end
        end
    end

    // ----------------------------------------------------------------
    // soft lane conversion to two's complement for the map core
    // ----------------------------------------------------------------
    logic [7*LANE_W-1:0] lanes_in;
    assign lanes_in = {soft_lane6, soft_lane5, soft_lane4, soft_lane3, soft_lane2, soft_lane1, soft_lane0};

    for (genvar i = 0; i < 7; i++) begin : g_lane
        logic [LANE_W-1:0] sm;
        logic [LANE_W-2:0] mag;
        assign sm = lanes_in[i*LANE_W +: LANE_W];
        assign mag = sm[LANE_W-2:0];
        // codes 0 and 32 both give zero; punctured all-zero words become erasures
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                map_lanes[i*LANE_W +: LANE_W] <= '0;
            end else if (sync_reset) begin
                map_lanes[i*LANE_W +: LANE_W] <= '0;
            end else begin
                map_lanes[i*LANE_W +: LANE_W] <= sm[LANE_W-1] ? LANE_W'(-{1'b0, mag}) : {1'b0, mag};
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencing state and captured configuration
    // ----------------------------------------------------------------
    tds_state_t state;
    logic [ADDR_W-1:0] k_len;
    logic [14:0] delay;
    logic [7:0] cfg_ni;
    logic [2:0] cfg_rate;
    logic [1:0] cfg_mode;
    logic [1:0] cfg_sld;
    logic cfg_maxlog;
    logic [14:0] cyc;
    logic stop_flag;
    logic [6:0] min_mag;
    logic [6:0] extr_mag;

    wire run = state == TDS_RUN;
    wire [3:0] ks_eff = (reg_ks > `TDS_KS_MAX) ? `TDS_KS_MAX : reg_ks;
    wire [17:0] k_prod = `TDS_K_UNIT * ({1'b0, ks_eff} + 5'h1);
    wire [14:0] delay_sel = (reg_sld == 2'h0) ? `TDS_DELAY_SHORT : (reg_sld == 2'h1) ? `TDS_DELAY_MID :
        `TDS_DELAY_LONG;
    // max-log-map adds one cycle to every half iteration
    wire [14:0] half_len = 15'(k_len) + delay + 15'h1 + 15'(cfg_maxlog);
    wire half_last = run & (cyc == half_len - 15'h1);
    wire is_final = (half_iter_index == cfg_ni) | stop_flag;
    wire finish = half_last & is_final;
    wire launch = (state == TDS_IDLE & start_req) | (finish & start_req);
    wire [14:0] rd_last = 15'(k_len) + `TDS_TAIL_LEN - 15'h1;
    wire rd_win = run & (cyc <= rd_last);
    wire [6:0] min_now = (map_extr_valid & run & (extr_mag < min_mag)) ? extr_mag : min_mag;
    wire stop_parity_ok = (cfg_mode == TDS_STOP_ANY) | (cfg_mode == TDS_STOP_ODD & half_iter_index[0]) |
        (cfg_mode == TDS_STOP_EVEN & ~half_iter_index[0]);
    wire stop_hit = half_last & ~is_final & (cfg_mode != TDS_STOP_FIXED) & stop_parity_ok &
        (min_now > reg_thr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= TDS_IDLE;
            {k_len, delay, cfg_ni, cfg_rate, cfg_mode, cfg_sld, cfg_maxlog} <= '0;
            {cyc, half_iter_index, stop_flag, stopped_early} <= '0;
            min_mag <= `TDS_MAG_MAX;
        end else if (sync_reset) begin
            state <= TDS_IDLE;
            {k_len, delay, cfg_ni, cfg_rate, cfg_mode, cfg_sld, cfg_maxlog} <= '0;
            {cyc, half_iter_index, stop_flag, stopped_early} <= '0;
            min_mag <= `TDS_MAG_MAX;
        end else if (launch) begin
            state <= TDS_RUN;
            k_len <= k_prod[ADDR_W-1:0];
            delay <= delay_sel;
            {cfg_ni, cfg_rate, cfg_mode, cfg_sld, cfg_maxlog} <= {reg_ni, reg_rate, reg_mode, reg_sld, reg_maxlog};
            {cyc, half_iter_index, stop_flag, stopped_early} <= '0;
            min_mag <= `TDS_MAG_MAX;
        end else if (finish) begin
            state <= TDS_IDLE;
        end else if (half_last) begin
            cyc <= '0;
            half_iter_index <= half_iter_index + 8'h1;
            stop_flag <= stop_hit;
            stopped_early <= stop_hit;
            min_mag <= `TDS_MAG_MAX;
        end else if (run) begin
            cyc <= cyc + 15'h1;
            min_mag <= min_now;
        end
    end

    assign map_delay_select = cfg_sld;
    assign map_max_log = cfg_maxlog;

    tds_extrinsic_conditioner #(
        .EXTR_W(EXTR_W)
    ) u_cond (
        .pclk(pclk),
        .presetn(presetn),
        .sync_reset(sync_reset),
        .extr_in(map_extr),
        .extr_in_valid(map_extr_valid),
        .limit(reg_limit),
        .scale(reg_scale),
        .extr_out(extr_apriori),
        .extr_out_valid(extr_apriori_valid),
        .extr_mag(extr_mag)
    );

    // ----------------------------------------------------------------
    // decoded output window and error estimate
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] out_idx_d1;
    logic win_d1;
    logic last_d1;
    logic odd_d1;
    logic [3:0] enc;

    wire [14:0] out_first = delay + 15'(cfg_maxlog) - 15'h1;
    wire [14:0] out_off = cyc - out_first;
    wire out_win = run & is_final & (cyc >= out_first) & (out_off < 15'(k_len));
    wire [ADDR_W-1:0] out_idx = out_off[ADDR_W-1:0];
    // feedback 1+D^3+D^4, parities 33, 25 and 37 octal
    wire fb = map_decision ^ enc[2] ^ enc[3];
    wire par1 = fb ^ enc[0] ^ enc[2] ^ enc[3];
    wire par2 = fb ^ enc[1] ^ enc[3];
    wire par3 = fb ^ enc[0] ^ enc[1] ^ enc[2] ^ enc[3];

    function automatic logic [3:0] err_calc(input logic odd, input logic [2:0] rate, input logic [6:0] s,
                                             input logic d, input logic y1, input logic y2, input logic y3,
                                             input logic kodd);
        logic [3:0] e;
        e = 4'h0;
        if (!odd) begin
            e[0] = d ^ s[0];
            unique case (rate)
                3'h2: e[1] = ~kodd & (y1 ^ s[1]);
                3'h3: e[1] = y1 ^ s[1];
                3'h4, 3'h5: e[3:2] = {y3 ^ s[2], y2 ^ s[1]};
                3'h6, 3'h7: e[3:1] = {y3 ^ s[3], y2 ^ s[2], y1 ^ s[1]};
                default: e = {3'h0, d ^ s[0]};
            endcase
        end else begin
            unique case (rate)
                3'h2: e[1] = kodd & (y1 ^ s[1]);
                3'h3: e[1] = y1 ^ s[2];
                3'h4: e[1] = y1 ^ s[3];
                3'h5: e[2:1] = {y2 ^ s[4], y1 ^ s[3]};
                3'h6: e[3:1] = {y3 ^ s[5], 1'b0, y1 ^ s[4]};
                3'h7: e[3:1] = {y3 ^ s[6], y2 ^ s[5], y1 ^ s[4]};
                default: e = 4'h0;
            endcase
        end
        return e;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {check_addr, out_idx_d1, win_d1, last_d1, odd_d1, enc} <= '0;
            {decoded_ready, decoded_addr, decoded_bit, err_estimate, output_terminal_count} <= '0;
        end else if (sync_reset) begin
            {check_addr, out_idx_d1, win_d1, last_d1, odd_d1, enc} <= '0;
            {decoded_ready, decoded_addr, decoded_bit, err_estimate, output_terminal_count} <= '0;
        end else begin
            check_addr <= cfg_ni[0] ? perm_addr : out_idx;
            out_idx_d1 <= out_idx;
            win_d1 <= out_win;
            last_d1 <= out_win & (out_idx == k_len - 1'b1);
            odd_d1 <= half_iter_index[0];
            enc <= win_d1 ? {enc[2:0], fb} : 4'h0;
            decoded_ready <= win_d1;
            decoded_addr <= check_addr;
            decoded_bit <= win_d1 & map_decision;
            err_estimate <= win_d1 ? err_calc(odd_d1, cfg_rate, check_sign, map_decision, par1, par2, par3,
                                              out_idx_d1[0]) : 4'h0;
            output_terminal_count <= last_d1;
        end
    end

    // ----------------------------------------------------------------
    // read strobe and registered status
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rx_read_strobe, rx_read_addr, input_terminal_count} <= '0;
            {input_ram_busy, decoder_busy, decode_done} <= '0;
        end else if (sync_reset) begin
            {rx_read_strobe, rx_read_addr, input_terminal_count} <= '0;
            {input_ram_busy, decoder_busy, decode_done} <= '0;
        end else begin
            rx_read_strobe <= rd_win & ~launch;
            rx_read_addr <= cyc[ADDR_W-1:0];
            input_terminal_count <= rd_win & is_final & (cyc == rd_last) & ~launch;
            if (launch) begin
                input_ram_busy <= 1'b1;
                decoder_busy <= 1'b1;
                decode_done <= 1'b0;
            end else begin
                if (rd_win & is_final & (cyc == rd_last)) begin
                    input_ram_busy <= 1'b0;
                end
                if (finish) begin
                    decoder_busy <= 1'b0;
                    decode_done <= 1'b1;
                end
            end
        end
    end

endmodule

// [turbo_decode_sequencer_bench.sv]
// Purpose: register, timing and early-stop tests of the sequencer
// Assumes: block size select 0, so K is 1784
// Notes: map core replaced by a constant extrinsic magnitude
module turbo_decode_sequencer_bench import tds_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int K = 1784;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, srst = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, rx_read_strobe, decoded_ready, decode_done, decoder_busy, counting = 1'b0;
    logic [13:0] rx_read_addr;
    logic [7:0] map_extr = 8'h05, half_iter_index, apri;
    logic [5:0] lane [7];
    int n_fail = 0, compares = 0, n_strobe, n_ready, n_cyc;

    tds_rx_ram i_ram (.pclk(pclk), .rx_read_strobe(rx_read_strobe), .rx_read_addr(rx_read_addr),
        .soft_lane0(lane[0]), .soft_lane1(lane[1]), .soft_lane2(lane[2]), .soft_lane3(lane[3]),
        .soft_lane4(lane[4]), .soft_lane5(lane[5]), .soft_lane6(lane[6]));
    tds_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sync_reset(srst), .start(start), .rx_read_strobe(rx_read_strobe), .rx_read_addr(rx_read_addr),
        .soft_lane0(lane[0]), .soft_lane1(lane[1]), .soft_lane2(lane[2]), .soft_lane3(lane[3]),
        .soft_lane4(lane[4]), .soft_lane5(lane[5]), .soft_lane6(lane[6]), .map_lanes(),
        .map_delay_select(), .map_max_log(), .map_extr(map_extr), .map_extr_valid(1'b1),
        .extr_apriori(apri), .extr_apriori_valid(), .map_decision(1'b0), .perm_addr(14'h0000),
        .check_addr(), .check_sign(7'h00), .decoded_ready(decoded_ready), .decoded_addr(),
        .decoded_bit(), .err_estimate(), .half_iter_index(half_iter_index), .decode_done(decode_done),
        .decoder_busy(decoder_busy), .output_terminal_count(), .input_ram_busy(),
        .input_terminal_count());

    initial begin
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (counting) begin
            n_strobe += int'(rx_read_strobe);
            n_ready += int'(decoded_ready);
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one decode: config, control word, extrinsic level, expected halves and cycles per half
    task automatic run(input logic [31:0] cfg, input logic [31:0] ctrl, input logic [7:0] extr,
        input int halves, input int h);
        logic [31:0] q;
        logic e;
        apb(1'b1, 12'h004, cfg, q, e);
        apb(1'b1, 12'h000, ctrl, q, e);
        map_extr <= extr;
        @(posedge pclk);
        start <= 1'b1;
        n_strobe = 0;
        n_ready = 0;
        n_cyc = 0;
        counting = 1'b1;
        // done from the previous block only clears on the launch edge, so look after it settles
        do begin
            @(posedge pclk);
            n_cyc++;
            start <= (n_cyc == 100);
            #1;
        end while (decode_done !== 1'b1 && n_cyc < 20000);
        counting = 1'b0;
        check(n_cyc, halves * h + 1);
        check(n_strobe, halves * (K + 4));
        check(n_ready, K);
        check(half_iter_index, halves - 1);
        check(apri, (extr > 8'h60) ? 8'h60 : extr);
        $display("test done: %0d halves in %0d cycles", halves, n_cyc);
    endtask

    task automatic close_out();
        $display("counts: %0d compares, %0d failures", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] q;
        logic e;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0, q, e);
        check(q, 32'h0017_2060);
        apb(1'b0, 12'h010, 32'h0, q, e);
        check({q[30:0], e}, 32'h0000_0001);
        $display("test done: register defaults");
        run(32'h0000_0330, 32'h0, 8'h7f, 4, K + 139);
        run(32'h0004_0030, 32'h2, 8'h05, 1, K + 268);
        run(32'h0008_0030, 32'h0, 8'h05, 1, K + 523);
        run(32'h0003_0530, 32'h0, 8'h7f, 2, K + 139);
        run(32'h0001_0530, 32'h0, 8'h7f, 3, K + 139);
        run(32'h0002_0530, 32'h0, 8'h7f, 2, K + 139);
        run(32'h0003_0130, 32'h0, 8'h05, 2, K + 139);
        // clobber the extrinsic settings, then a synchronous reset must restore them
        apb(1'b1, 12'h008, 32'h0, q, e);
        srst <= 1'b1;
        @(posedge pclk);
        srst <= 1'b0;
        apb(1'b0, 12'h008, 32'h0, q, e);
        check(q, 32'h0017_2060);
        check(decode_done, 1'b0);
        $display("test done: synchronous reset");
        close_out();
    end

    initial begin
        #5000000;
        n_fail++;
        close_out();
    end
endmodule
